// ==== rtl/accumulator_alu.sv ====
// accumulator, carry flag and memory-operand sequencer of the 8-bit core
// assumes: memory returns read data one cycle after memRdEn, same clock,
// and the decoder holds no op while busy is high
`default_nettype none
// Behaviour
// RULE1 - add-with-carry memory operand into accumulator
// RULE2 - addition sets carry on overflow, else clears
// RULE3 - add-to-memory writes sum back to memory
// RULE4 - bank-zero add reads and writes bank zero
// RULE5 - immediate add result goes to accumulator
// RULE6 - subtract-with-borrow uses inverted carry as borrow
// RULE7 - subtraction clears carry on borrow, else sets
// RULE8 - subtract-to-memory writes difference to memory
// RULE9 - immediate subtract result kept in accumulator
// RULE10 - immediate AND updates accumulator
// RULE11 - AND-to-memory writes AND to memory
// RULE12 - OR-to-memory writes OR to memory
// RULE13 - logic ops keep carry, unsigned bytes
module accumulator_alu #(
    parameter int ADDR_W = 8,   // data memory address width
    parameter int BANK_W = 2    // bank select width
) (
    // clock and reset
    input  wire logic                clk_sys,
    input  wire logic                reset_n,
    // op request from the decoder
    input  wire logic                opValid,
    input  wire alu_pkg::opcode_t    opCode,
    input  wire logic [7:0]          opImm,
    input  wire logic [ADDR_W-1:0]   opAddr,
    input  wire logic [BANK_W-1:0]   curBank,
    // direct accumulator and flag writes from other instructions
    input  wire logic                accWrEn,
    input  wire logic [7:0]          accWrData,
    input  wire logic                carryWrEn,
    input  wire logic                carryWrData,
    // data memory
    output logic                     memRdEn,
    output logic                     memWrEn,
    output logic [ADDR_W-1:0]        memAddr,
    output logic [BANK_W-1:0]        memBank,
    output logic [7:0]               memWrData,
    input  wire logic [7:0]          memRdData,
    // state
    output logic [7:0]               accOut,
    output logic                     carryOut,
    output logic                     busy,
    output logic                     done
);
    alu_pkg::state_t  state_reg;      // sequencer state
    alu_pkg::opcode_t op_reg;         // op being executed
    logic [7:0]       imm_reg;        // latched immediate
    logic [7:0]       acc_reg;        // accumulator
    logic             carry_reg;      // carry flag
    logic             isImm;          // operand from immediate
    logic             toMem;          // result to memory
    alu_pkg::aluFn_t  fn;             // decoded function
    logic [7:0]       opB;            // second operand
    logic [7:0]       aluRes;         // combinational result
    logic             aluCarry;       // combinational carry
    logic             accept;         // request taken this cycle

    assign accept = opValid && state_reg == alu_pkg::ST_IDLE;

    // decode of the latched op
    always_comb begin
        isImm = 1'b0;
        toMem = 1'b0;
        fn    = alu_pkg::FN_ADD;
        unique case (op_reg)
            alu_pkg::OP_ADC_AM: fn = alu_pkg::FN_ADC;
            alu_pkg::OP_ADC_MA: begin
                fn    = alu_pkg::FN_ADC;
                toMem = 1'b1;
            end
            alu_pkg::OP_ADD_AM: fn = alu_pkg::FN_ADD;
            alu_pkg::OP_ADD_MA: toMem = 1'b1;  // RULE3
            alu_pkg::OP_BANK_ZERO_ADD_TO_MEMORY_OP:  toMem = 1'b1;  // RULE4
            alu_pkg::OP_ADD_AI: isImm = 1'b1;  // RULE5
            alu_pkg::OP_SBC_AM: fn = alu_pkg::FN_SBC;  // RULE6
            alu_pkg::OP_SBC_MA: begin
                fn    = alu_pkg::FN_SBC;
                toMem = 1'b1;
            end
            alu_pkg::OP_SUB_AM: fn = alu_pkg::FN_SUB;
            alu_pkg::OP_SUB_MA: begin
                fn    = alu_pkg::FN_SUB;
                toMem = 1'b1;  // RULE8
            end
            alu_pkg::OP_SUB_AI: begin
                fn    = alu_pkg::FN_SUB;
                isImm = 1'b1;  // RULE9
            end
            alu_pkg::OP_AND_AM: fn = alu_pkg::FN_AND;
            alu_pkg::OP_AND_MA: begin
                fn    = alu_pkg::FN_AND;
                toMem = 1'b1;  // RULE11
            end
            alu_pkg::OP_AND_AI: begin
                fn    = alu_pkg::FN_AND;
                isImm = 1'b1;  // RULE10
            end
            alu_pkg::OP_OR_MA: begin
                fn    = alu_pkg::FN_OR;
                toMem = 1'b1;  // RULE12
            end
            default: fn = alu_pkg::FN_ADD;
        endcase
    end

    // operand select: immediate or returned memory byte
    assign opB = isImm ? imm_reg : memRdData;

    alu_core #(
        .WIDTH (alu_pkg::DATA_W)
    ) u_core (
        .opA      (acc_reg),
        .opB      (opB),
        .carryIn  (carry_reg),
        .fn       (fn),
        .result   (aluRes),
        .carryOut (aluCarry)
    );

    // sequencer: idle, memory read, execute
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= alu_pkg::ST_IDLE;
        end else begin
            unique case (state_reg)
                alu_pkg::ST_IDLE: begin
                    // immediate forms skip the read
                    if (accept && (opCode == alu_pkg::OP_ADD_AI ||
                                   opCode == alu_pkg::OP_SUB_AI ||
                                   opCode == alu_pkg::OP_AND_AI)) begin
                        state_reg <= alu_pkg::ST_EXEC;
                    end else if (accept) begin
                        state_reg <= alu_pkg::ST_READ;
                    end
                end
                alu_pkg::ST_READ: state_reg <= alu_pkg::ST_EXEC;
                alu_pkg::ST_EXEC: state_reg <= alu_pkg::ST_IDLE;
                default:          state_reg <= alu_pkg::ST_IDLE;
            endcase
        end
    end

    // op, immediate, address and bank latched on acceptance
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            op_reg  <= alu_pkg::OP_ADD_AM;
            imm_reg <= 8'h00;
            memAddr <= '0;
            memBank <= '0;
        end else if (accept) begin
            op_reg  <= opCode;
            imm_reg <= opImm;
            memAddr <= opAddr;
            // bank-zero form ignores the current bank
            memBank <= (opCode == alu_pkg::OP_BANK_ZERO_ADD_TO_MEMORY_OP) ? '0 : curBank;  // RULE4
        end
    end

    // read strobe high for exactly the read state
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            memRdEn <= 1'b0;
        end else begin
            memRdEn <= accept && !(opCode == alu_pkg::OP_ADD_AI ||
                                   opCode == alu_pkg::OP_SUB_AI ||
                                   opCode == alu_pkg::OP_AND_AI);
        end
    end

    // memory write-back, one cycle after execute
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            memWrEn   <= 1'b0;
            memWrData <= 8'h00;
        end else begin
            memWrEn <= state_reg == alu_pkg::ST_EXEC && toMem;
            if (state_reg == alu_pkg::ST_EXEC && toMem) begin
                memWrData <= aluRes;  // RULE3 RULE8 RULE11 RULE12
            end
        end
    end

    // accumulator: execute wins over a direct write
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            acc_reg <= alu_pkg::ACC_RESET;
        end else if (state_reg == alu_pkg::ST_EXEC) begin
            if (!toMem) begin
                acc_reg <= aluRes;  // RULE1 RULE5 RULE9 RULE10
            end
        end else if (accWrEn) begin
            acc_reg <= accWrData;
        end
    end

    // carry flag: updated by arithmetic, held by logic ops
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            carry_reg <= alu_pkg::CARRY_RESET;
        end else if (state_reg == alu_pkg::ST_EXEC) begin
            carry_reg <= aluCarry;  // RULE2 RULE7 RULE13
        end else if (carryWrEn) begin
            carry_reg <= carryWrData;
        end
    end

    // status outputs
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            busy <= accept || state_reg == alu_pkg::ST_READ;
            done <= state_reg == alu_pkg::ST_EXEC;
        end
    end

    assign accOut   = acc_reg;
    assign carryOut = carry_reg;

    // independent reference values for checking
    logic       exec;
    logic [8:0] expSum;
    logic [8:0] expDiff;
    assign exec    = state_reg == alu_pkg::ST_EXEC;
    assign expSum  = {1'b0, acc_reg} + {1'b0, opB} +
                     {8'h00, (op_reg == alu_pkg::OP_ADC_AM || op_reg == alu_pkg::OP_ADC_MA)
                             && carry_reg};
    assign expDiff = {1'b0, acc_reg} - {1'b0, opB} -
                     {8'h00, (op_reg == alu_pkg::OP_SBC_AM || op_reg == alu_pkg::OP_SBC_MA)
                             && !carry_reg};

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    sequence b0Issue;
        accept && opCode == alu_pkg::OP_BANK_ZERO_ADD_TO_MEMORY_OP;
    endsequence
    sequence b0ReadWrite;
        memRdEn && memBank == '0 ##2 memWrEn && memBank == '0;
    endsequence

    a_adc_acc_sum: assert property (exec && op_reg == alu_pkg::OP_ADC_AM |=> // RULE1
        accOut == $past(expSum[7:0])) else $error("adc accumulator wrong");
    a_add_carry_out: assert property (exec && fn inside {alu_pkg::FN_ADD, alu_pkg::FN_ADC} // RULE2
        |=> carryOut == $past(expSum[8])) else $error("add carry wrong");
    a_add_mem_wb: assert property (exec && op_reg == alu_pkg::OP_ADD_MA |=> // RULE3
        memWrEn && memWrData == $past(expSum[7:0]) && $stable(accOut))
        else $error("add to memory wrong");
    a_bank0_add: assert property (b0Issue |=> b0ReadWrite) // RULE4
        else $error("bank zero add not in bank zero");
    a_add_imm: assert property (exec && op_reg == alu_pkg::OP_ADD_AI |=> // RULE5
        accOut == $past(expSum[7:0])) else $error("immediate add wrong");
    a_sbc_borrow_in: assert property (exec && op_reg == alu_pkg::OP_SBC_AM |=> // RULE6
        accOut == $past(expDiff[7:0])) else $error("subtract with borrow wrong");
    a_sub_carry_flag: assert property (exec && // RULE7
        fn inside {alu_pkg::FN_SUB, alu_pkg::FN_SBC}
        |=> carryOut == !$past(expDiff[8])) else $error("borrow flag wrong");
    a_sub_mem_wb: assert property (exec && op_reg == alu_pkg::OP_SUB_MA |=> // RULE8
        memWrEn && memWrData == $past(expDiff[7:0])) else $error("subtract to memory wrong");
    a_sub_imm: assert property (exec && op_reg == alu_pkg::OP_SUB_AI |=> // RULE9
        accOut == $past(expDiff[7:0])) else $error("immediate subtract wrong");
    a_and_imm: assert property (exec && op_reg == alu_pkg::OP_AND_AI |=> // RULE10
        accOut == ($past(accOut) & $past(imm_reg))) else $error("immediate and wrong");
    a_and_mem_wb: assert property (exec && op_reg == alu_pkg::OP_AND_MA |=> // RULE11
        memWrEn && memWrData == ($past(accOut) & $past(memRdData)))
        else $error("and to memory wrong");
    a_or_mem_wb: assert property (exec && op_reg == alu_pkg::OP_OR_MA |=> // RULE12
        memWrEn && memWrData == ($past(accOut) | $past(memRdData)))
        else $error("or to memory wrong");
    a_logic_keeps_carry: assert property (exec && // RULE13
        fn inside {alu_pkg::FN_AND, alu_pkg::FN_OR}
        |=> $stable(carryOut)) else $error("logic op changed carry");
endmodule
`default_nettype wire

// ==== rtl/alu_pkg.sv ====
// constants, operation codes and reset values for the accumulator datapath
// assumes: one core clock, the instruction decoder drives the op code
`default_nettype none
package alu_pkg;
    localparam int          DATA_W      = 8;        // operand and result width
    localparam logic [7:0]  ACC_RESET   = 8'h00;    // accumulator after reset
    localparam logic        CARRY_RESET = 1'b0;     // carry flag after reset
    localparam int          RD_LATENCY  = 1;        // memory data one cycle after read

    // instruction codes handled by this datapath
    typedef enum logic [3:0] {
        OP_ADC_AM  = 4'h0,  // acc <- acc + mem + carry
        OP_ADC_MA  = 4'h1,  // mem <- acc + mem + carry
        OP_ADD_AM  = 4'h2,  // acc <- acc + mem
        OP_ADD_MA  = 4'h3,  // mem <- acc + mem
        OP_BANK_ZERO_ADD_TO_MEMORY_OP   = 4'h4,  // bank_zero_add_to_memory_op
        OP_ADD_AI  = 4'h5,  // acc <- acc + imm
        OP_SBC_AM  = 4'h6,  // subtract_with_borrow_op into acc
        OP_SBC_MA  = 4'h7,  // subtract_with_borrow_op into mem
        OP_SUB_AM  = 4'h8,  // acc <- acc - mem
        OP_SUB_MA  = 4'h9,  // mem <- acc - mem
        OP_SUB_AI  = 4'ha,  // acc <- acc - imm
        OP_AND_AM  = 4'hb,  // acc <- acc & mem
        OP_AND_MA  = 4'hc,  // mem <- acc & mem
        OP_AND_AI  = 4'hd,  // acc <- acc & imm
        OP_OR_MA   = 4'he   // mem <- acc | mem
    } opcode_t;

    // arithmetic function of the core
    typedef enum logic [2:0] {
        FN_ADD = 3'h0,
        FN_ADC = 3'h1,
        FN_SUB = 3'h2,
        FN_SBC = 3'h3,
        FN_AND = 3'h4,
        FN_OR  = 3'h5
    } aluFn_t;

    // sequencer states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_READ = 3'b010,
        ST_EXEC = 3'b100
    } state_t;
endpackage
`default_nettype wire

// ==== rtl/alu_core.sv ====
// combinational 8-bit add/subtract/logic unit with carry in and out
// assumes: caller registers the result and the carry
`default_nettype none
module alu_core #(
    parameter int WIDTH = 8
) (
    // operands
    input  wire logic [WIDTH-1:0] opA,
    input  wire logic [WIDTH-1:0] opB,
    input  wire logic             carryIn,
    input  wire alu_pkg::aluFn_t  fn,
    // results
    output logic      [WIDTH-1:0] result,
    output logic                  carryOut
);
    logic [WIDTH:0] wide;   // sum with carry bit

    // subtract is acc + ~b + 1; carry out set means no borrow
    always_comb begin
        wide     = '0;
        result   = '0;
        carryOut = carryIn;
        unique case (fn)
            alu_pkg::FN_ADD: begin
                wide = {1'b0, opA} + {1'b0, opB};  // RULE5
            end
            alu_pkg::FN_ADC: begin
                wide = {1'b0, opA} + {1'b0, opB} + {{WIDTH{1'b0}}, carryIn};  // RULE1
            end
            alu_pkg::FN_SUB: begin
                wide = {1'b0, opA} + {1'b0, ~opB} + {{WIDTH{1'b0}}, 1'b1};  // RULE9
            end
            alu_pkg::FN_SBC: begin
                // clear carry acts as one borrow in
                wide = {1'b0, opA} + {1'b0, ~opB} + {{WIDTH{1'b0}}, carryIn};  // RULE6
            end
            alu_pkg::FN_AND: begin
                wide = {1'b0, opA & opB};  // RULE10
            end
            alu_pkg::FN_OR: begin
                wide = {1'b0, opA | opB};  // RULE12
            end
            default: begin
                wide = '0;
            end
        endcase
        result = wide[WIDTH-1:0];
        // logic ops keep the flag
        if (fn != alu_pkg::FN_AND && fn != alu_pkg::FN_OR) begin
            carryOut = wide[WIDTH];  // RULE2 RULE7
        end
    end
endmodule
`default_nettype wire

// ==== sim/accumulator_alu_tb_top.sv ====
// self-checking bench for the accumulator datapath: every op code, carry cases
// assumes: rtl/alu_pkg.sv and rtl/accumulator_alu.sv compiled first, 20 MHz clock
`default_nettype none
module accumulator_alu_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // clock and reset
    logic                clk_sys;
    logic                reset_n;
    // op request
    logic                opValid;
    alu_pkg::opcode_t    opCode;
    logic [7:0]          opImm;
    logic [7:0]          opAddr;
    logic [1:0]          curBank;
    // direct writes
    logic                accWrEn;
    logic [7:0]          accWrData;
    logic                carryWrEn;
    logic                carryWrData;
    // data memory side
    logic                memRdEn;
    logic                memWrEn;
    logic [7:0]          memAddr;
    logic [1:0]          memBank;
    logic [7:0]          memWrData;
    logic [7:0]          memRdData = 8'h00;  // only the memory model drives it
    // state outputs
    logic [7:0]          accOut;
    logic                carryOut;
    logic                busy;
    logic                done;
    // bench bookkeeping
    logic [7:0]          mem [0:3][0:255];  // banked data memory model
    logic [7:0]          expAcc;            // shadow accumulator
    logic                expC;              // shadow carry flag
    int                  errTotal;
    int                  nTests;

    accumulator_alu #(.ADDR_W(8), .BANK_W(2)) dut (
        .clk_sys(clk_sys), .reset_n(reset_n), .opValid(opValid), .opCode(opCode),
        .opImm(opImm), .opAddr(opAddr), .curBank(curBank), .accWrEn(accWrEn),
        .accWrData(accWrData), .carryWrEn(carryWrEn), .carryWrData(carryWrData),
        .memRdEn(memRdEn), .memWrEn(memWrEn), .memAddr(memAddr), .memBank(memBank),
        .memWrData(memWrData), .memRdData(memRdData), .accOut(accOut),
        .carryOut(carryOut), .busy(busy), .done(done)
    );

    // 50 ns clock
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // memory model: data the cycle after a read, a changing pattern otherwise
    always @(posedge clk_sys) begin
        if (memRdEn) begin
            memRdData <= mem[memBank][memAddr];
        end else begin
            memRdData <= ~memRdData;
        end
        if (memWrEn) begin
            mem[memBank][memAddr] <= memWrData;
        end
    end

    // one comparison, counted
    task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
        nTests++;
        if (seen !== exp) begin
            errTotal++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // verdict and end of run
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", nTests, errTotal);
        if (errTotal == 0 && nTests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // direct accumulator and carry load while idle
    task automatic set_state(input logic [7:0] a, input logic c);
        @(posedge clk_sys);
        accWrEn     <= 1'b1;
        accWrData   <= a;
        carryWrEn   <= 1'b1;
        carryWrData <= c;
        @(posedge clk_sys);
        accWrEn     <= 1'b0;
        carryWrEn   <= 1'b0;
        expAcc = a;
        expC   = c;
        @(negedge clk_sys);
    endtask

    // one op with preloaded memory byte, judged against the shadow state
    task automatic run(input alu_pkg::opcode_t op, input logic [7:0] imm, input logic [7:0] addr,
                       input logic [1:0] bank, input logic [7:0] m);
        logic [8:0] t;
        logic [7:0] b;
        logic [1:0] eb;
        logic       toMem;
        logic       isSub;
        logic       isImm;
        int         n;
        eb    = (op == alu_pkg::OP_BANK_ZERO_ADD_TO_MEMORY_OP) ? 2'h0 : bank;
        mem[eb][addr] = m;
        isImm = op inside {alu_pkg::OP_ADD_AI, alu_pkg::OP_SUB_AI, alu_pkg::OP_AND_AI};
        b     = isImm ? imm : m;
        toMem = op inside {alu_pkg::OP_ADC_MA, alu_pkg::OP_ADD_MA, alu_pkg::OP_BANK_ZERO_ADD_TO_MEMORY_OP,
                           alu_pkg::OP_SBC_MA, alu_pkg::OP_SUB_MA, alu_pkg::OP_AND_MA,
                           alu_pkg::OP_OR_MA};
        isSub = op inside {alu_pkg::OP_SBC_AM, alu_pkg::OP_SBC_MA, alu_pkg::OP_SUB_AM,
                           alu_pkg::OP_SUB_MA, alu_pkg::OP_SUB_AI};
        case (op)
            alu_pkg::OP_ADC_AM, alu_pkg::OP_ADC_MA: t = {1'b0, expAcc} + {1'b0, b} + {8'h00, expC};
            alu_pkg::OP_SBC_AM, alu_pkg::OP_SBC_MA: t = {1'b0, expAcc} - {1'b0, b} - {8'h00, ~expC};
            alu_pkg::OP_SUB_AM, alu_pkg::OP_SUB_MA, alu_pkg::OP_SUB_AI:
                t = {1'b0, expAcc} - {1'b0, b};
            alu_pkg::OP_AND_AM, alu_pkg::OP_AND_MA, alu_pkg::OP_AND_AI: t = {expC, expAcc & b};
            alu_pkg::OP_OR_MA: t = {expC, expAcc | b};
            default: t = {1'b0, expAcc} + {1'b0, b};
        endcase
        @(posedge clk_sys);
        opValid <= 1'b1;
        opCode  <= op;
        opImm   <= imm;
        opAddr  <= addr;
        curBank <= bank;
        @(posedge clk_sys);
        opValid <= 1'b0;
        n = 0;
        @(negedge clk_sys);
        while (done !== 1'b1 && n < 8) begin
            @(negedge clk_sys);
            n++;
        end
        check("done", {8'h00, done}, 9'h001);
        // done two cycles after the taking edge for memory ops, one for immediates
        check("latency", 9'(n), isImm ? 9'h001 : 9'h002);
        expC = isSub ? ~t[8] : t[8];
        check("carry", {8'h00, carryOut}, {8'h00, expC});
        if (toMem) begin
            check("write strobe", {8'h00, memWrEn}, 9'h001);
            check("write data", {1'b0, memWrData}, {1'b0, t[7:0]});
            check("bank", {7'h00, memBank}, {7'h00, eb});
            check("address", {1'b0, memAddr}, {1'b0, addr});
        end else begin
            expAcc = t[7:0];
        end
        check("accumulator", {1'b0, accOut}, {1'b0, expAcc});
    endtask

    // state right after reset
    task automatic t_reset();
        check("reset acc", {1'b0, accOut}, {1'b0, alu_pkg::ACC_RESET});
        check("reset carry", {8'h00, carryOut}, {8'h00, alu_pkg::CARRY_RESET});
        check("reset busy", {8'h00, busy}, 9'h000);
        $display("test reset finished");
    endtask

    // add with carry in, both destinations
    task automatic t_adc();
        set_state(8'hff, 1'b1);
        run(alu_pkg::OP_ADC_AM, 8'h00, 8'h00, 2'h1, 8'h00);
        run(alu_pkg::OP_ADC_MA, 8'h00, 8'h01, 2'h1, 8'h10);
        $display("test adc finished");
    endtask

    // plain adds, memory and immediate, carry set and cleared
    task automatic t_add();
        set_state(8'h80, 1'b0);
        run(alu_pkg::OP_ADD_AM, 8'h00, 8'h02, 2'h2, 8'h80);
        run(alu_pkg::OP_ADD_MA, 8'h00, 8'h03, 2'h2, 8'h01);
        run(alu_pkg::OP_ADD_AI, 8'hfe, 8'h04, 2'h0, 8'h55);
        run(alu_pkg::OP_ADD_AI, 8'h02, 8'h05, 2'h0, 8'h55);
        $display("test add finished");
    endtask

    // bank-zero add with another bank selected
    task automatic t_bank_zero_add_to_memory_op();
        set_state(8'h7f, 1'b0);
        run(alu_pkg::OP_BANK_ZERO_ADD_TO_MEMORY_OP, 8'h00, 8'h06, 2'h3, 8'h81);
        $display("test bank zero add finished");
    endtask

    // subtracts with and without borrow in, every form
    task automatic t_sub();
        set_state(8'h10, 1'b0);
        run(alu_pkg::OP_SBC_AM, 8'h00, 8'h07, 2'h1, 8'h0f);
        run(alu_pkg::OP_SBC_AM, 8'h00, 8'h08, 2'h1, 8'h00);
        run(alu_pkg::OP_SBC_MA, 8'h00, 8'h09, 2'h1, 8'h01);
        run(alu_pkg::OP_SUB_AM, 8'h00, 8'h0a, 2'h2, 8'h01);
        run(alu_pkg::OP_SUB_MA, 8'h00, 8'h0b, 2'h2, 8'hff);
        run(alu_pkg::OP_SUB_AI, 8'h01, 8'h0c, 2'h0, 8'h00);
        $display("test subtract finished");
    endtask

    // logic ops leave carry alone, set and clear
    task automatic t_logic();
        set_state(8'hf0, 1'b1);
        run(alu_pkg::OP_AND_AI, 8'h3c, 8'h0d, 2'h0, 8'h00);
        run(alu_pkg::OP_AND_MA, 8'h00, 8'h0e, 2'h1, 8'hff);
        run(alu_pkg::OP_OR_MA, 8'h00, 8'h0f, 2'h1, 8'h0f);
        set_state(8'h0f, 1'b0);
        run(alu_pkg::OP_AND_AM, 8'h00, 8'h10, 2'h2, 8'h5a);
        $display("test logic finished");
    endtask

    // watchdog well past the expected run length
    initial begin
        repeat (3000) @(posedge clk_sys);
        errTotal++;
        report_and_stop();
    end

    // main sequence
    initial begin
        errTotal    = 0;
        nTests      = 0;
        reset_n     = 1'b0;
        opValid     = 1'b0;
        opCode      = alu_pkg::OP_ADD_AM;
        opImm       = 8'h00;
        opAddr      = 8'h00;
        curBank     = 2'h0;
        accWrEn     = 1'b0;
        accWrData   = 8'h00;
        carryWrEn   = 1'b0;
        carryWrData = 1'b0;
        expAcc      = 8'h00;
        expC        = 1'b0;
        repeat (10) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(negedge clk_sys);
        t_reset();
        t_adc();
        t_add();
        t_bank_zero_add_to_memory_op();
        t_sub();
        t_logic();
        report_and_stop();
    end
endmodule
`default_nettype wire
